// file: src/hcs_status_top.sv
// Purpose: status reporting of a data-link channel behind an AHB-Lite slave
// Assumes: all datapath inputs come from logic on hclk
// Notes: zero wait-state slave, frame end follows its last byte by a cycle
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
//
// Notes on behaviour
// - tx overflow flag on 33rd byte written; cleared by reset command or half moved.
// - tx write-enable status high while host may still write bytes.
// - repeat status bit mirrors the repeat request level.
// - line-inactive flag when no fill flags or frames arrive.
// - bom status bit: 0 ordinary mode, 1 message mode; needs esf and auto switch.
// - status byte written into rx fifo as last byte at frame end.
// - frame valid bit 0 when length is not whole bytes.
// - 16-bit address: 4 bytes invalid, or 3 or 4 with checksum forwarded.
// - 8-bit address: 3 bytes invalid, or 2 or 3 with checksum forwarded.
// - frames below those lengths are discarded without status.
// - overflow bit set when data was lost during the frame.
// - checksum bit 1 when check passed, 0 when failed.
// - in ss7 mode aborted bit set beyond maximum octet count.
// - high address byte compared with two registers and broadcast values.
// - high code: 00 second, 01 broadcast, 10/11 first with c/r bit.
// - identical registers report a first-register code.
// - ss7 code: 00 invalid, 01 fill-in, 10 link status, 11 message.
// - low byte match bit: 1 first register, 0 second register.
// - frame length 1 to 4095 across high and low count registers.
// - low five count bits give bytes now held in rx fifo.
// - message-end pulse when frame with status byte sits in rx fifo.
module hcs_status_top
	import hcs_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// transmit fifo events
	input wire logic tx_byte_write,
	input wire logic tx_half_moved,
	input wire logic tx_reset_command,
	input wire logic tx_repeat_request,
	// receive line activity
	input wire logic rx_bit_en,
	input wire logic rx_flag_seen,
	input wire logic rx_frame_active,
	input wire logic bom_detected,
	// receive frame stream
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_frame_end,
	input wire logic [2:0] rx_bit_residue,
	input wire logic rx_crc_ok,
	input wire logic rx_frame_bom,
	input wire logic rx_data_lost,
	input wire logic [5:0] rx_fifo_level,
	// receive fifo write side
	output logic rx_fifo_wr,
	output logic [7:0] rx_fifo_wr_data,
	output logic rx_fifo_discard,
	output logic rx_message_end
);

	// configuration and state registers
	hcs_cfg_s cfg;
	logic [31:0] addr_compare;
	hcs_rx_status_s rx_frame_status;
	logic [11:0] frame_length;
	logic tx_fifo_overflow;
	logic wr_pend;
	logic [11:0] wr_addr;

	// per-frame reception state
	logic [11:0] rx_count;
	logic [7:0] byte0;
	logic [7:0] byte1;
	logic [7:0] byte2;
	logic frame_lost;
	logic rx_aborted_flag;

	// ---- bus decode ----
	wire logic addr_phase;
	wire logic [11:0] req_ofs;
	wire logic [31:0] rd_word;
	wire logic [7:0] sis_byte;
	wire logic [7:0] count_low_byte;
	wire logic [7:0] count_high_byte;

	assign addr_phase = hsel && htrans[1] && hready;
	assign req_ofs = haddr[11:0];

	// ---- transmit side ----
	wire logic [5:0] tx_count;
	wire logic tx_full;
	wire logic tx_overflow_set;
	wire logic tx_overflow_clr;
	wire logic tx_fifo_write_enable;
	wire logic tx_repeat_status;

	assign tx_full = tx_count >= HCS_TX_HALF_BYTES;
	assign tx_overflow_set = tx_byte_write && tx_full;
	assign tx_overflow_clr = tx_reset_command || tx_half_moved;
	assign tx_fifo_write_enable = !tx_full && !tx_fifo_overflow;
	assign tx_repeat_status = tx_repeat_request;

	hcs_counter #(
		.W(6)
	) u_tx_count (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(tx_overflow_clr),
		.step(tx_byte_write),
		.count(tx_count)
	);

	// ---- line inactivity ----
	wire logic [4:0] idle_bits;
	wire logic line_seen;
	wire logic rx_line_inactive;
	wire logic bit_oriented_message_mode;

	assign line_seen = rx_flag_seen || rx_frame_active;
	assign rx_line_inactive = idle_bits >= HCS_INACTIVE_BITS;
	assign bit_oriented_message_mode = cfg.esf_format && cfg.auto_switch && bom_detected;

	hcs_counter #(
		.W(5)
	) u_idle_count (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(line_seen),
		.step(rx_bit_en),
		.count(idle_bits)
	);

	// ---- mode decode ----
	wire logic mode_ss7;
	wire logic mode_a16;
	wire logic mode_a8;
	wire logic strip_off;

	assign mode_ss7 = cfg.operating_mode_select == HCS_MODE_SS7;
	assign mode_a16 = cfg.operating_mode_select == HCS_MODE_ADDR16;
	assign mode_a8 = cfg.operating_mode_select == HCS_MODE_ADDR8;
	assign strip_off = !cfg.rx_checksum_forward;

	// ---- length classes ----
	wire logic len_short_invalid;
	wire logic len_discard;

	// too short but still reported, invalid
	assign len_short_invalid = (mode_a16 && (strip_off ? rx_count == 12'h4 : (rx_count == 12'h3 || rx_count == 12'h4)))
		|| (mode_a8 && (strip_off ? rx_count == 12'h3 : (rx_count == 12'h2 || rx_count == 12'h3)));
	// shorter still: dropped silently
	assign len_discard = (rx_count == 12'h0)
		|| (mode_a16 && (strip_off ? rx_count < 12'h4 : rx_count < 12'h3))
		|| (mode_a8 && (strip_off ? rx_count < 12'h3 : rx_count < 12'h2));

	// ---- address comparison ----
	wire logic [7:0] low_byte;
	wire logic hi_first;
	wire logic hi_second;
	wire logic hi_bcast;
	wire logic lo_first;
	wire logic lo_second;

	assign low_byte = mode_a16 ? byte1 : byte0;

	// c/r bit excluded from the high byte compare
	hcs_addr_match #(
		.BCAST_EN(1'b1)
	) u_high_match (
		.addr_byte(byte0),
		.first_ref(addr_compare[HCS_ACR_HIGH_FIRST_LSB +: 8]),
		.second_ref(addr_compare[HCS_ACR_HIGH_SECOND_LSB +: 8]),
		.mask(HCS_CR_MASK),
		.hit_first(hi_first),
		.hit_second(hi_second),
		.hit_bcast(hi_bcast)
	);

	hcs_addr_match #(
		.BCAST_EN(1'b0)
	) u_low_match (
		.addr_byte(low_byte),
		.first_ref(addr_compare[HCS_ACR_LOW_FIRST_LSB +: 8]),
		.second_ref(addr_compare[HCS_ACR_LOW_SECOND_LSB +: 8]),
		.mask(HCS_NO_MASK),
		.hit_first(lo_first),
		.hit_second(lo_second),
		.hit_bcast()
	);

	// ---- status byte assembly ----
	wire logic frame_valid;
	wire logic [1:0] high_code;
	wire logic [1:0] unit_code;
	wire logic [1:0] high_addr_match_code;
	wire logic low_addr_match;
	wire logic [5:0] length_indicator;
	hcs_rx_status_s next_status;

	assign frame_valid = (rx_bit_residue == 3'h0) && !len_short_invalid;
	// first register checked first so identical registers report 10/11
	assign high_code = hi_first ? {1'b1, byte0[HCS_CR_BIT]}
		: hi_bcast ? HCS_HA_BCAST
		: HCS_HA_SECOND;
	assign length_indicator = byte2[5:0];
	assign unit_code = !frame_valid ? HCS_SU_INVALID
		: (length_indicator == 6'h00) ? HCS_SU_FILL
		: (length_indicator <= HCS_LI_LSSU_MAX) ? HCS_SU_LINK_STATUS
		: HCS_SU_MESSAGE;
	assign high_addr_match_code = mode_ss7 ? unit_code : (mode_a16 ? high_code : HCS_HA_SECOND);
	// lo_second needs no term: it reads as 0 like a miss
	assign low_addr_match = lo_first && !mode_ss7;

	assign next_status.frame_valid = frame_valid;
	assign next_status.rx_overflow = frame_lost || rx_data_lost;
	assign next_status.crc_ok = rx_crc_ok;
	assign next_status.rx_aborted = rx_aborted_flag && mode_ss7;
	assign next_status.high_addr_match_code = high_addr_match_code;
	assign next_status.frame_format_kind = !rx_frame_bom;
	assign next_status.low_addr_match = low_addr_match;

	wire logic frame_report;
	wire logic frame_drop;
	wire logic abort_hit;
	assign frame_report = rx_frame_end && !len_discard;
	assign frame_drop = rx_frame_end && len_discard;
	assign abort_hit = rx_byte_valid && rx_count >= HCS_SS7_MAX_OCTETS;

	// ---- frame reception state ----
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_count <= 12'h000;
			frame_lost <= 1'b0;
			rx_aborted_flag <= 1'b0;
		end else if (rx_frame_end) begin
			rx_count <= 12'h000;
			frame_lost <= 1'b0;
			rx_aborted_flag <= 1'b0;
		end else begin
			if (rx_byte_valid && rx_count != HCS_LEN_MAX)
				rx_count <= rx_count + 12'h001;
			if (rx_data_lost)
				frame_lost <= 1'b1;
			if (abort_hit)
				rx_aborted_flag <= 1'b1;
		end
	end

	// address and length-indicator bytes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			byte0 <= 8'h00;
			byte1 <= 8'h00;
			byte2 <= 8'h00;
		end else if (rx_byte_valid) begin
			if (rx_count == 12'h0)
				byte0 <= rx_byte;
			if (rx_count == 12'h1)
				byte1 <= rx_byte;
			if (rx_count == 12'h2)
				byte2 <= rx_byte;
		end
	end

	// fifo write: data bytes, then status byte at frame end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_fifo_wr <= 1'b0;
			rx_fifo_wr_data <= 8'h00;
			rx_fifo_discard <= 1'b0;
			rx_message_end <= 1'b0;
		end else begin
			rx_fifo_wr <= rx_byte_valid || frame_report;
			rx_fifo_wr_data <= frame_report ? next_status : rx_byte;
			rx_fifo_discard <= frame_drop;
			rx_message_end <= frame_report;
		end
	end

	// latched status and length of the last reported frame
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_frame_status <= '0;
			frame_length <= 12'h000;
		end else if (frame_report) begin
			rx_frame_status <= next_status;
			frame_length <= rx_count;
		end
	end

	// tx overflow: set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tx_fifo_overflow <= 1'b0;
		else if (tx_overflow_set)
			tx_fifo_overflow <= 1'b1;
		else if (tx_overflow_clr)
			tx_fifo_overflow <= 1'b0;
	end

	// ---- register read mux ----
	assign sis_byte = {tx_fifo_overflow, tx_fifo_write_enable, tx_repeat_status, 1'b0,
		rx_line_inactive, 3'b000} | {7'h00, bit_oriented_message_mode};
	assign count_low_byte = {frame_length[7:5], rx_fifo_level[4:0]};
	assign count_high_byte = {4'h0, frame_length[11:8]};
	assign rd_word = (req_ofs == HCS_OFS_SIGNALING_STATUS) ? {24'h000000, sis_byte}
		: (req_ofs == HCS_OFS_RX_FRAME_STATUS) ? {24'h000000, rx_frame_status}
		: (req_ofs == HCS_OFS_RX_BYTE_COUNT_LOW) ? {24'h000000, count_low_byte}
		: (req_ofs == HCS_OFS_RX_BYTE_COUNT_HIGH) ? {24'h000000, count_high_byte}
		: (req_ofs == HCS_OFS_MODE_CONFIG) ? {26'h0, cfg}
		: (req_ofs == HCS_OFS_ADDR_COMPARE) ? addr_compare
		: 32'h00000000;

	// ---- ahb-lite slave ----
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= HCS_RDATA_RESET;
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= addr_phase && hwrite;
			if (addr_phase) begin
				wr_addr <= req_ofs;
				if (!hwrite)
					hrdata <= rd_word;
			end
		end
	end

	// writes land in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg <= HCS_MODE_CONFIG_RESET;
			addr_compare <= HCS_ADDR_COMPARE_RESET;
		end else if (wr_pend) begin
			if (wr_addr == HCS_OFS_MODE_CONFIG)
				cfg <= hwdata[5:0];
			if (wr_addr == HCS_OFS_ADDR_COMPARE)
				addr_compare <= hwdata;
		end
	end

	// hsize is fixed to words by the bus master
	wire logic unused_ok;
	assign unused_ok = &{1'b0, haddr[31:12], hsize, htrans[0], lo_second};

endmodule // hcs_status_top
`default_nettype wire

// file: shared/hcs_pkg.sv
// Purpose: constants, offsets and carriers of the data-link status block
// Assumes: 32-bit AHB-Lite register words, one word per register
// Notes: byte offsets are compared against haddr[11:0]
package hcs_pkg;

	// register byte offsets
	localparam int HCS_ADDR_W = 12;
	localparam logic [11:0] HCS_OFS_SIGNALING_STATUS = 12'h064;
	localparam logic [11:0] HCS_OFS_RX_FRAME_STATUS = 12'h068;
	localparam logic [11:0] HCS_OFS_RX_BYTE_COUNT_LOW = 12'h06c;
	localparam logic [11:0] HCS_OFS_RX_BYTE_COUNT_HIGH = 12'h070;
	localparam logic [11:0] HCS_OFS_MODE_CONFIG = 12'h080;
	localparam logic [11:0] HCS_OFS_ADDR_COMPARE = 12'h084;

	// reset values
	localparam logic [5:0] HCS_MODE_CONFIG_RESET = 6'h00;
	localparam logic [31:0] HCS_ADDR_COMPARE_RESET = 32'h00000000;
	localparam logic [31:0] HCS_RDATA_RESET = 32'h00000000;

	// signaling status bit positions
	localparam int HCS_SIS_TX_OVERFLOW = 7;
	localparam int HCS_SIS_TX_WRITE_ENABLE = 6;
	localparam int HCS_SIS_TX_REPEAT = 5;
	localparam int HCS_SIS_RX_LINE_INACTIVE = 3;
	localparam int HCS_SIS_BOM_MODE = 0;

	// address compare register byte fields
	localparam int HCS_ACR_HIGH_FIRST_LSB = 0;
	localparam int HCS_ACR_HIGH_SECOND_LSB = 8;
	localparam int HCS_ACR_LOW_FIRST_LSB = 16;
	localparam int HCS_ACR_LOW_SECOND_LSB = 24;

	// operating modes
	localparam logic [2:0] HCS_MODE_SS7 = 3'h1;
	localparam logic [2:0] HCS_MODE_ADDR8 = 3'h2;
	localparam logic [2:0] HCS_MODE_ADDR16 = 3'h3;

	// counts and fixed values
	localparam logic [5:0] HCS_TX_HALF_BYTES = 6'h20;
	localparam logic [4:0] HCS_INACTIVE_BITS = 5'h10;
	localparam logic [11:0] HCS_SS7_MAX_OCTETS = 12'h117;
	localparam logic [11:0] HCS_LEN_MAX = 12'hfff;
	localparam logic [7:0] HCS_BCAST_A = 8'hfe;
	localparam logic [7:0] HCS_BCAST_B = 8'hfc;
	localparam logic [7:0] HCS_CR_MASK = 8'hfd;
	localparam logic [7:0] HCS_NO_MASK = 8'hff;
	localparam int HCS_CR_BIT = 1;

	// high address / unit type codes
	localparam logic [1:0] HCS_HA_SECOND = 2'h0;
	localparam logic [1:0] HCS_HA_BCAST = 2'h1;
	localparam logic [1:0] HCS_HA_FIRST = 2'h2;
	localparam logic [1:0] HCS_SU_INVALID = 2'h0;
	localparam logic [1:0] HCS_SU_FILL = 2'h1;
	localparam logic [1:0] HCS_SU_LINK_STATUS = 2'h2;
	localparam logic [1:0] HCS_SU_MESSAGE = 2'h3;
	localparam logic [5:0] HCS_LI_LSSU_MAX = 6'h02;

	typedef struct packed {
		logic frame_valid;
		logic rx_overflow;
		logic crc_ok;
		logic rx_aborted;
		logic [1:0] high_addr_match_code;
		logic frame_format_kind;
		logic low_addr_match;
	} hcs_rx_status_s;

	typedef struct packed {
		logic auto_switch;
		logic esf_format;
		logic rx_checksum_forward;
		logic [2:0] operating_mode_select;
	} hcs_cfg_s;

endpackage

// file: src/hcs_counter.sv
// Purpose: saturating up counter with synchronous clear
// Assumes: clear and step come from the hclk domain
// Notes: clear wins over step
`timescale 1ns/1ps
`default_nettype none
module hcs_counter #(
	parameter int W = 6
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// control
	input wire logic clear,
	input wire logic step,
	// value
	output logic [W-1:0] count
);

	wire logic at_max;
	assign at_max = &count;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			count <= '0;
		else if (clear)
			count <= '0;
		else if (step && !at_max)
			count <= count + 1'b1;
	end

endmodule // hcs_counter
`default_nettype wire

// file: src/hcs_addr_match.sv
// Purpose: compares an address byte against two registers and broadcast
// Assumes: mask clears the bits excluded from comparison
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module hcs_addr_match
	import hcs_pkg::*;
#(
	parameter bit BCAST_EN = 1'b0
) (
	// compare inputs
	input wire logic [7:0] addr_byte,
	input wire logic [7:0] first_ref,
	input wire logic [7:0] second_ref,
	input wire logic [7:0] mask,
	// results
	output logic hit_first,
	output logic hit_second,
	output logic hit_bcast
);

	wire logic [7:0] masked;
	assign masked = addr_byte & mask;
	assign hit_first = masked == (first_ref & mask);
	assign hit_second = masked == (second_ref & mask);
	assign hit_bcast = BCAST_EN && (masked == (HCS_BCAST_A & mask) || masked == (HCS_BCAST_B & mask));

endmodule // hcs_addr_match
`default_nettype wire

// file: testbench/hcs_status_monitor.sv
// Purpose: port checks of the data-link status block
// Assumes: bound into hcs_status_top, one clock domain
// Notes: watches the receive frame path
`timescale 1ns/1ps
`default_nettype none
module hcs_status_monitor (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// frame stream
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_frame_end,
	input wire logic [2:0] rx_bit_residue,
	input wire logic rx_crc_ok,
	input wire logic rx_data_lost,
	// fifo write side
	input wire logic rx_fifo_wr,
	input wire logic [7:0] rx_fifo_wr_data,
	input wire logic rx_fifo_discard,
	input wire logic rx_message_end
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_FWD: assert property (rx_byte_valid |=> rx_fifo_wr && rx_fifo_wr_data == $past(rx_byte))
		else $error("received byte not forwarded");
	AST_IDLE: assert property (!rx_byte_valid && !rx_frame_end |=> !rx_fifo_wr)
		else $error("fifo write without cause");
	AST_END: assert property (rx_frame_end |=> rx_message_end != rx_fifo_discard)
		else $error("frame end not reported once");
	AST_ME: assert property (rx_message_end |-> rx_fifo_wr && $past(rx_frame_end))
		else $error("message end out of place");
	AST_DISC: assert property (rx_fifo_discard |-> !rx_fifo_wr && $past(rx_frame_end))
		else $error("discard out of place");
	AST_RES: assert property (rx_frame_end && rx_bit_residue != 3'h0 |=> rx_fifo_discard || !rx_fifo_wr_data[7])
		else $error("odd bit length reported valid");
	AST_CRC: assert property (rx_frame_end |=> rx_fifo_discard || rx_fifo_wr_data[5] == $past(rx_crc_ok))
		else $error("checksum bit wrong");
	AST_LOST: assert property (rx_frame_end && rx_data_lost |=> rx_fifo_discard || rx_fifo_wr_data[6])
		else $error("overflow bit missing");
	cover property (rx_message_end && !rx_fifo_wr_data[7]);
	cover property (rx_fifo_discard);
	cover property (rx_message_end && rx_fifo_wr_data[4]);
endmodule // hcs_status_monitor
bind hcs_status_top hcs_status_monitor mon (.hclk, .hresetn, .rx_byte_valid, .rx_byte, .rx_frame_end,
	.rx_bit_residue, .rx_crc_ok, .rx_data_lost, .rx_fifo_wr, .rx_fifo_wr_data, .rx_fifo_discard, .rx_message_end);
`default_nettype wire

// file: testbench/hcs_line_station.sv
// Purpose: remote data-link station feeding the receive side
// Assumes: one byte per cycle, frame end a cycle after the last byte
// Notes: idle data line shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module hcs_line_station (
	// clock
	input wire logic hclk,
	// line activity
	output var logic rx_bit_en,
	output var logic rx_flag_seen,
	output var logic rx_frame_active,
	// frame stream
	output var logic rx_byte_valid,
	output var logic [7:0] rx_byte,
	output var logic rx_frame_end,
	output var logic [2:0] rx_bit_residue,
	output var logic rx_crc_ok,
	output var logic rx_frame_bom,
	output var logic rx_data_lost
);
	initial begin
		{rx_bit_en, rx_flag_seen, rx_frame_active, rx_byte_valid, rx_frame_end, rx_byte} = '0;
		{rx_bit_residue, rx_crc_ok, rx_frame_bom, rx_data_lost} = '0;
	end
	// ctl: residue, crc ok, data lost, bom frame
	task automatic send_frame(input logic [7:0] b0, b1, b2, input int n, input logic [5:0] ctl);
		for (int i = 0; i < n; i++) begin
			{rx_byte_valid, rx_frame_active} <= 2'h3;
			rx_byte <= i == 0 ? b0 : i == 1 ? b1 : i == 2 ? b2 : i[7:0];
			@(posedge hclk);
		end
		rx_byte_valid <= 1'b0;
		rx_byte <= ~rx_byte;
		rx_frame_end <= 1'b1;
		{rx_bit_residue, rx_crc_ok, rx_data_lost, rx_frame_bom} <= ctl;
		@(posedge hclk);
		{rx_frame_end, rx_frame_active, rx_data_lost} <= 3'h0;
	endtask
	// n signaling bits, with or without fill flags
	task automatic line(input int n, input logic f);
		repeat (n) begin
			{rx_bit_en, rx_flag_seen} <= {1'b1, f};
			@(posedge hclk);
		end
		{rx_bit_en, rx_flag_seen} <= 2'h0;
	endtask
endmodule // hcs_line_station
`default_nettype wire

// file: testbench/hdlc_channel_status_reporting_test.sv
// Purpose: register and frame status tests of the data-link status block
// Assumes: zero wait-state slave, station model on the receive side
// Notes: expected status bytes worked out by hand per frame
`timescale 1ns/1ps
`default_nettype none
module hdlc_channel_status_reporting_test;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd_data;
	logic [1:0] htrans;
	logic [2:0] hsize, rx_bit_residue;
	logic tx_byte_write, tx_half_moved, tx_reset_command, tx_repeat_request, bom_detected;
	logic rx_bit_en, rx_flag_seen, rx_frame_active, rx_byte_valid, rx_frame_end;
	logic rx_crc_ok, rx_frame_bom, rx_data_lost, rx_fifo_wr, rx_fifo_discard, rx_message_end;
	logic [7:0] rx_byte, rx_fifo_wr_data, stat;
	logic [5:0] rx_fifo_level;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	int ndisc = 0;
	assign hready = hreadyout;
	hcs_status_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
		.hrdata, .hresp, .tx_byte_write, .tx_half_moved, .tx_reset_command, .tx_repeat_request, .rx_bit_en,
		.rx_flag_seen, .rx_frame_active, .bom_detected, .rx_byte_valid, .rx_byte, .rx_frame_end, .rx_bit_residue,
		.rx_crc_ok, .rx_frame_bom, .rx_data_lost, .rx_fifo_level, .rx_fifo_wr, .rx_fifo_wr_data, .rx_fifo_discard,
		.rx_message_end);
	hcs_line_station stn (.hclk, .rx_bit_en, .rx_flag_seen, .rx_frame_active, .rx_byte_valid, .rx_byte,
		.rx_frame_end, .rx_bit_residue, .rx_crc_ok, .rx_frame_bom, .rx_data_lost);
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (rx_message_end === 1'b1) stat <= rx_fifo_wr_data;
		if (rx_fifo_discard === 1'b1) ndisc <= ndisc + 1;
		if (cycles == 20000) begin
			mismatches++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 20'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd_data = hrdata;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		ahb(a, 1'b0, 32'h0);
		chk(rd_data, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic txw(input int n);
		repeat (n) begin
			tx_byte_write <= 1'b1;
			@(posedge hclk);
		end
		tx_byte_write <= 1'b0;
		@(posedge hclk);
	endtask
	// one frame under a mode, then status byte in fifo and register
	task automatic fr(input logic [5:0] cfg, input logic [7:0] b0, b1, b2, input int n,
		input logic [5:0] ctl, input logic [7:0] m, input logic [7:0] exp);
		ahb(12'h080, 1'b1, {26'h0, cfg});
		stn.send_frame(b0, b1, b2, n, ctl);
		repeat (2) @(posedge hclk);
		ahb(12'h068, 1'b0, 32'h0);
		chk({24'h0, stat & m}, {24'h0, exp});
		chk(rd_data & {24'h0, m}, {24'h0, exp});
	endtask
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{tx_byte_write, tx_half_moved, tx_reset_command, tx_repeat_request, bom_detected} = '0;
		{hsize, rx_fifo_level} = {3'h2, 6'h07};
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(12'h064, 32'h40);
		rd(12'h000, 32'h0);
		ahb(12'h084, 1'b1, 32'h22119080);
		rd(12'h084, 32'h22119080);
		for (int k = 1; k < 3; k++) begin
			txw(32);
			rd(12'h064, 32'h00);
			txw(1);
			rd(12'h064, 32'h80);
			{tx_half_moved, tx_reset_command} <= k[1:0];
			@(posedge hclk);
			{tx_half_moved, tx_reset_command} <= 2'h0;
			@(posedge hclk);
			rd(12'h064, 32'h40);
		end
		tx_repeat_request <= 1'b1;
		rd(12'h064, 32'h60);
		tx_repeat_request <= 1'b0;
		stn.line(16, 1'b0);
		rd(12'h064, 32'h48);
		stn.line(1, 1'b1);
		rd(12'h064, 32'h40);
		bom_detected <= 1'b1;
		ahb(12'h080, 1'b1, 32'h33);
		rd(12'h064, 32'h41);
		ahb(12'h080, 1'b1, 32'h23);
		rd(12'h064, 32'h40);
		bom_detected <= 1'b0;
		fr(6'h03, 8'h82, 8'h11, 8'h00, 6, 6'h04, 8'hff, 8'haf);
		fr(6'h03, 8'hfe, 8'h22, 8'h00, 6, 6'h02, 8'hff, 8'hc6);
		fr(6'h03, 8'h90, 8'h11, 8'h00, 6, 6'h1c, 8'hff, 8'h23);
		fr(6'h03, 8'h80, 8'h11, 8'h00, 4, 6'h04, 8'hff, 8'h2b);
		fr(6'h0b, 8'h80, 8'h11, 8'h00, 3, 6'h04, 8'hff, 8'h2b);
		fr(6'h03, 8'h80, 8'h11, 8'h00, 3, 6'h04, 8'hff, 8'h2b);
		chk(ndisc, 32'h1);
		fr(6'h02, 8'h11, 8'h00, 8'h00, 3, 6'h04, 8'hff, 8'h23);
		fr(6'h0a, 8'h11, 8'h00, 8'h00, 2, 6'h04, 8'hff, 8'h23);
		fr(6'h02, 8'h22, 8'h00, 8'h00, 4, 6'h04, 8'hff, 8'ha2);
		ahb(12'h084, 1'b1, 32'h22118080);
		fr(6'h03, 8'h80, 8'h11, 8'h00, 5, 6'h04, 8'hff, 8'hab);
		fr(6'h03, 8'h80, 8'h11, 8'h00, 5, 6'h05, 8'h02, 8'h00);
		fr(6'h03, 8'h80, 8'h11, 8'h00, 300, 6'h04, 8'hff, 8'hab);
		rd(12'h06c, 32'h27);
		rd(12'h070, 32'h01);
		rx_fifo_level <= 6'h1f;
		rd(12'h06c, 32'h3f);
		fr(6'h01, 8'h00, 8'h00, 8'h00, 4, 6'h04, 8'hfc, 8'ha4);
		fr(6'h01, 8'h00, 8'h00, 8'h02, 4, 6'h04, 8'hfc, 8'ha8);
		fr(6'h01, 8'h00, 8'h00, 8'h03, 279, 6'h04, 8'hfc, 8'hac);
		fr(6'h01, 8'h00, 8'h00, 8'h03, 280, 6'h04, 8'hfc, 8'hbc);
		fr(6'h01, 8'h00, 8'h00, 8'h03, 4, 6'h1c, 8'hfc, 8'h20);
		chk(ndisc, 32'h1);
		finish_test();
	end
endmodule // hdlc_channel_status_reporting_test
`default_nettype wire
